// File: csl_ctrl.sv
// Converter hibernate control and current-limit switch sequencing slice
`timescale 1ns/1ps
// What this block does
// RL1 - Behaviour codes 000 to 011 keep settings, apply image voltage, force standby, or both.
// RL2 - Codes 100 and 101 force linear mode without or with image voltage, 110 is reserved, 111 disables the output.
// RL3 - The source select picks the software hibernate bit or one of three low-power request inputs.
// RL4 - An asserted general-purpose hibernate input puts the converter in hibernate regardless of the source.
// RL5 - The seven-bit image voltage code in 25 mV steps is passed to the converter for hibernate.
// RL6 - The image voltage field resets to code 000 0110, the 1.0V level.
// RL7 - On overcurrent the fault action ignores it, disables the switch, or shuts down the system.
// RL8 - The startup slot keeps the switch off, turns it on in slots 1 to 14, or on entering active.
// RL9 - The shutdown slot turns the switch off in slots 1 to 14, or on entering off for codes 0000 and 1111.
// RL10 - In hibernate the switch is disabled unless the keep bit is set, which holds its active setting.
// RL11 - The hibernate protection bit enables bulk detection while the switch is off in hibernate.
// RL12 - The active protection bit enables bulk detection while the switch is off in active.
// RL13 - The power state machine restores every field to its fixed default.
// RL14 - A fault with a non-ignore action also raises an interrupt.
// RL15 - Hibernate settings apply while the trigger is asserted and normal settings return when it drops.
module csl_ctrl
  import csl_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic psm_reset_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic hibernate_reg_bit_i,
  input wire logic low_power_request_1_i,
  input wire logic low_power_request_2_i,
  input wire logic low_power_request_3_i,
  input wire logic gpio_hibernate_i,
  input wire logic seq_startup_stb_i,
  input wire logic seq_shutdown_stb_i,
  input wire logic [3:0] seq_slot_i,
  input wire logic seq_enter_active_i,
  input wire logic seq_enter_off_i,
  input wire logic overcurrent_i,
  output logic [15:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output logic conv_hib_active_o,
  output logic conv_disable_o,
  output logic conv_linear_mode_o,
  output logic conv_standby_o,
  output logic conv_use_image_o,
  output logic [6:0] conv_image_voltage_o,
  output logic switch_en_o,
  output logic bulk_detect_en_o,
  output logic fault_irq_o,
  output logic system_shutdown_o
);

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  // Hibernate behaviour code to converter controls
  function automatic csl_conv_ctrl_type decode_behaviour(input logic [2:0] code);
    csl_conv_ctrl_type c;
    c = '0;
    case (code)
      CSL_HIB_KEEP: c = '0; // RL1
      CSL_HIB_IMAGE: c.use_image = 1'b1; // RL1
      CSL_HIB_STANDBY: c.standby = 1'b1; // RL1
      CSL_HIB_STANDBY_IMAGE: begin // RL1
        c.standby = 1'b1;
        c.use_image = 1'b1;
      end
      CSL_HIB_LINEAR: c.linear_mode = 1'b1; // RL2
      CSL_HIB_LINEAR_IMAGE: begin // RL2
        c.linear_mode = 1'b1;
        c.use_image = 1'b1;
      end
      CSL_HIB_DISABLE: c.disable_out = 1'b1; // RL2
      default: c = '0; // Reserved code changes nothing
    endcase
    return c;
  endfunction : decode_behaviour

  // Slot code names a numbered slot 1..14
  function automatic logic is_numbered_slot(input logic [3:0] code);
    return (code != CSL_SLOT_NONE) && (code != CSL_SLOT_EDGE);
  endfunction : is_numbered_slot

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  csl_conv_cfg_type conv_cfg_q;
  csl_sw_cfg_type sw_cfg_q;
  logic wr_conv;
  logic wr_sw;
  csl_conv_word_type conv_wr_word;
  csl_sw_word_type sw_wr_word;
  csl_conv_word_type conv_rd_word;
  csl_sw_word_type sw_rd_word;

  // Register words seen through their field layouts
  assign conv_wr_word = reg_wdata_i;
  assign sw_wr_word = reg_wdata_i;
  assign conv_rd_word = '{conv_hibernate_behaviour: conv_cfg_q.conv_hibernate_behaviour,
                          conv_hibernate_source_sel: conv_cfg_q.conv_hibernate_source_sel,
                          conv_image_voltage: conv_cfg_q.conv_image_voltage,
                          default: '0};
  assign sw_rd_word = '{switch_fault_action: sw_cfg_q.switch_fault_action,
                        switch_startup_slot: sw_cfg_q.switch_startup_slot,
                        switch_shutdown_slot: sw_cfg_q.switch_shutdown_slot,
                        switch_hibernate_keep: sw_cfg_q.switch_hibernate_keep,
                        switch_bulk_detect_hibernate: sw_cfg_q.switch_bulk_detect_hibernate,
                        switch_bulk_detect_active: sw_cfg_q.switch_bulk_detect_active,
                        default: '0};

  assign wr_conv = reg_wr_i && (reg_addr_i == CSL_CONV6_HIB_CFG_ADDR);
  assign wr_sw = reg_wr_i && (reg_addr_i == CSL_SWITCH_CTRL_ADDR);

  // Converter hibernate register, state machine restore wins over a write
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      conv_cfg_q <= CSL_CONV_DEFAULT; // RL6
    end else if (psm_reset_i) begin
      conv_cfg_q <= CSL_CONV_DEFAULT; // RL13
    end else if (wr_conv) begin
      conv_cfg_q.conv_hibernate_behaviour <= conv_wr_word.conv_hibernate_behaviour;
      conv_cfg_q.conv_hibernate_source_sel <= conv_wr_word.conv_hibernate_source_sel;
      conv_cfg_q.conv_image_voltage <= conv_wr_word.conv_image_voltage;
    end
  end

  // Switch control register
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sw_cfg_q <= CSL_SW_DEFAULT;
    end else if (psm_reset_i) begin
      sw_cfg_q <= CSL_SW_DEFAULT; // RL13
    end else if (wr_sw) begin
      sw_cfg_q.switch_fault_action <= sw_wr_word.switch_fault_action;
      sw_cfg_q.switch_startup_slot <= sw_wr_word.switch_startup_slot;
      sw_cfg_q.switch_shutdown_slot <= sw_wr_word.switch_shutdown_slot;
      sw_cfg_q.switch_hibernate_keep <= sw_wr_word.switch_hibernate_keep;
      sw_cfg_q.switch_bulk_detect_hibernate <= sw_wr_word.switch_bulk_detect_hibernate;
      sw_cfg_q.switch_bulk_detect_active <= sw_wr_word.switch_bulk_detect_active;
    end
  end

  // Read data one cycle after the strobe, unmapped reads zero
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= '0;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (!reg_rd_i) begin
        reg_rdata_o <= '0;
      end else if (reg_addr_i == CSL_CONV6_HIB_CFG_ADDR) begin
        reg_rdata_o <= conv_rd_word;
      end else if (reg_addr_i == CSL_SWITCH_CTRL_ADDR) begin
        reg_rdata_o <= sw_rd_word;
      end else begin
        reg_rdata_o <= '0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Hibernate trigger and converter controls
  // ---------------------------------------------------------------
  logic trig_sel;
  logic hib_now;
  csl_conv_ctrl_type conv_ctrl;

  // Selected trigger, or-ed with the pin hibernate input
  always_comb begin
    case (conv_cfg_q.conv_hibernate_source_sel)
      CSL_SRC_SW_BIT: trig_sel = hibernate_reg_bit_i; // RL3
      CSL_SRC_LPR1: trig_sel = low_power_request_1_i; // RL3
      CSL_SRC_LPR2: trig_sel = low_power_request_2_i; // RL3
      CSL_SRC_LPR3: trig_sel = low_power_request_3_i; // RL3
      default: trig_sel = 1'b0;
    endcase
  end

  assign hib_now = trig_sel || gpio_hibernate_i; // RL4
  assign conv_ctrl = hib_now ? decode_behaviour(conv_cfg_q.conv_hibernate_behaviour)
                             : '0; // RL15

  // Converter control outputs follow the trigger level
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      conv_hib_active_o <= 1'b0;
      conv_disable_o <= 1'b0;
      conv_linear_mode_o <= 1'b0;
      conv_standby_o <= 1'b0;
      conv_use_image_o <= 1'b0;
      conv_image_voltage_o <= CSL_DEF_IMAGE_VOLT;
    end else begin
      conv_hib_active_o <= hib_now; // RL15
      conv_disable_o <= conv_ctrl.disable_out;
      conv_linear_mode_o <= conv_ctrl.linear_mode;
      conv_standby_o <= conv_ctrl.standby;
      conv_use_image_o <= conv_ctrl.use_image;
      conv_image_voltage_o <= conv_cfg_q.conv_image_voltage; // RL5
    end
  end

  // ---------------------------------------------------------------
  // Switch sequencing and fault reaction
  // ---------------------------------------------------------------
  logic sw_on_q;
  logic sw_on_d;
  logic oc_prev_q;
  logic fault_evt;
  logic start_hit;
  logic stop_hit;
  logic sw_eff;

  assign fault_evt = overcurrent_i && !oc_prev_q && sw_on_q;
  assign start_hit = (seq_startup_stb_i
                      && is_numbered_slot(sw_cfg_q.switch_startup_slot)
                      && (seq_slot_i == sw_cfg_q.switch_startup_slot))
                     || (seq_enter_active_i
                      && (sw_cfg_q.switch_startup_slot == CSL_SLOT_EDGE)); // RL8
  assign stop_hit = (seq_shutdown_stb_i
                     && is_numbered_slot(sw_cfg_q.switch_shutdown_slot)
                     && (seq_slot_i == sw_cfg_q.switch_shutdown_slot))
                    || (seq_enter_off_i
                     && !is_numbered_slot(sw_cfg_q.switch_shutdown_slot)); // RL9

  // Fault disable beats shutdown slot, which beats startup
  always_comb begin
    sw_on_d = sw_on_q;
    if (fault_evt && (sw_cfg_q.switch_fault_action == CSL_FAULT_DISABLE)) begin
      sw_on_d = 1'b0; // RL7
    end else if (stop_hit) begin
      sw_on_d = 1'b0; // RL9
    end else if (start_hit) begin
      sw_on_d = 1'b1; // RL8
    end
  end

  assign sw_eff = sw_on_d && !(hib_now && !sw_cfg_q.switch_hibernate_keep); // RL10

  // Switch state and overcurrent edge history
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sw_on_q <= 1'b0;
      oc_prev_q <= 1'b0;
    end else begin
      sw_on_q <= sw_on_d;
      oc_prev_q <= overcurrent_i;
    end
  end

  // Switch drive and bulk detection while the switch is off
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      switch_en_o <= 1'b0;
      bulk_detect_en_o <= 1'b0;
    end else begin
      switch_en_o <= sw_eff;
      bulk_detect_en_o <= !sw_eff && (hib_now ? sw_cfg_q.switch_bulk_detect_hibernate
                                              : sw_cfg_q.switch_bulk_detect_active); // RL11 RL12
    end
  end

  // Fault interrupt and system shutdown pulses
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      fault_irq_o <= 1'b0;
      system_shutdown_o <= 1'b0;
    end else begin
      fault_irq_o <= fault_evt && (sw_cfg_q.switch_fault_action != CSL_FAULT_IGNORE); // RL14
      system_shutdown_o <= fault_evt
                           && sw_cfg_q.switch_fault_action[CSL_FAULT_SYS_BIT]; // RL7
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  a_fault_irq_raise: assert property ( // RL14
    fault_evt && (sw_cfg_q.switch_fault_action != CSL_FAULT_IGNORE) |=> fault_irq_o)
    else $error("fault interrupt missing");
  a_fault_irq_quiet: assert property ( // RL14
    !(fault_evt && (sw_cfg_q.switch_fault_action != CSL_FAULT_IGNORE)) |=> !fault_irq_o)
    else $error("spurious fault interrupt");
  a_fault_sys_off: assert property ( // RL7
    fault_evt && sw_cfg_q.switch_fault_action[CSL_FAULT_SYS_BIT]
      |=> system_shutdown_o && fault_irq_o)
    else $error("system shutdown missing");
  a_fault_sw_off: assert property ( // RL7
    fault_evt && (sw_cfg_q.switch_fault_action == CSL_FAULT_DISABLE) |=> !sw_on_q && !switch_en_o)
    else $error("switch not disabled on fault");
  a_startup_slot_on: assert property ( // RL8
    start_hit && !stop_hit && !fault_evt |=> sw_on_q)
    else $error("switch not started in its slot");
  a_startup_none_off: assert property ( // RL8
    !sw_on_q && (sw_cfg_q.switch_startup_slot == CSL_SLOT_NONE) && !wr_sw |=> !sw_on_q)
    else $error("switch started while disabled");
  a_shutdown_off: assert property ( // RL9
    seq_enter_off_i && (sw_cfg_q.switch_shutdown_slot == CSL_SLOT_EDGE) |=> !sw_on_q)
    else $error("switch not off on entering off");
  a_hib_sw_disable: assert property ( // RL10
    hib_now && !sw_cfg_q.switch_hibernate_keep |=> !switch_en_o)
    else $error("switch on in hibernate");
  a_bulk_when_off: assert property ( // RL11 RL12
    switch_en_o |-> !bulk_detect_en_o)
    else $error("bulk detection with switch on");
  a_gpio_hib_force: assert property ( // RL4
    gpio_hibernate_i |=> conv_hib_active_o)
    else $error("pin hibernate ignored");
  a_hib_release: assert property ( // RL15
    conv_hib_active_o && !hib_now |=> !conv_hib_active_o && !conv_standby_o
      && !conv_linear_mode_o && !conv_use_image_o && !conv_disable_o)
    else $error("hibernate settings not released");
  a_psm_restore: assert property ( // RL13
    psm_reset_i |=> conv_cfg_q == CSL_CONV_DEFAULT && sw_cfg_q == CSL_SW_DEFAULT)
    else $error("defaults not restored");

  c_fault_shutdown: cover property (fault_evt && sw_cfg_q.switch_fault_action[CSL_FAULT_SYS_BIT]);
  c_slot_start: cover property (seq_startup_stb_i && start_hit ##1 switch_en_o);
  c_hib_linear: cover property (conv_linear_mode_o && conv_use_image_o);
  c_hib_keep: cover property (hib_now && sw_cfg_q.switch_hibernate_keep && switch_en_o);

endmodule : csl_ctrl

// File: csl_ctrl_test.sv
// Self-checking testbench for the converter/switch low-power control slice
`timescale 1ns/1ps
module csl_ctrl_test;
  import csl_pkg::*;

  // ---------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic psm_reset_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, hibernate_reg_bit_i = 1'b0;
  logic low_power_request_1_i = 1'b0, low_power_request_2_i = 1'b0;
  logic low_power_request_3_i = 1'b0, gpio_hibernate_i = 1'b0;
  logic seq_startup_stb_i = 1'b0, seq_shutdown_stb_i = 1'b0;
  logic seq_enter_active_i = 1'b0, seq_enter_off_i = 1'b0, overcurrent_i = 1'b0;
  logic [3:0] seq_slot_i = 4'h0;
  logic [15:0] reg_rdata_o;
  logic [6:0] conv_image_voltage_o;
  logic reg_rvalid_o, conv_hib_active_o, conv_disable_o, conv_linear_mode_o;
  logic conv_standby_o, conv_use_image_o, switch_en_o, bulk_detect_en_o;
  logic fault_irq_o, system_shutdown_o;
  int error_cnt = 0;
  int num_checks = 0;
  int cycle_cnt = 0;
  // Expected {disable, linear, standby, image} per behaviour code
  logic [3:0] mode_exp [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h0, 4'h8};

  csl_ctrl csl_ctrl_inst (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .psm_reset_i(psm_reset_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .hibernate_reg_bit_i(hibernate_reg_bit_i),
    .low_power_request_1_i(low_power_request_1_i),
    .low_power_request_2_i(low_power_request_2_i),
    .low_power_request_3_i(low_power_request_3_i),
    .gpio_hibernate_i(gpio_hibernate_i), .seq_startup_stb_i(seq_startup_stb_i),
    .seq_shutdown_stb_i(seq_shutdown_stb_i), .seq_slot_i(seq_slot_i),
    .seq_enter_active_i(seq_enter_active_i), .seq_enter_off_i(seq_enter_off_i),
    .overcurrent_i(overcurrent_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .conv_hib_active_o(conv_hib_active_o),
    .conv_disable_o(conv_disable_o), .conv_linear_mode_o(conv_linear_mode_o),
    .conv_standby_o(conv_standby_o), .conv_use_image_o(conv_use_image_o),
    .conv_image_voltage_o(conv_image_voltage_o), .switch_en_o(switch_en_o),
    .bulk_detect_en_o(bulk_detect_en_o), .fault_irq_o(fault_irq_o),
    .system_shutdown_o(system_shutdown_o)
  );

  // ---------------------------------------------------------------
  // Clock and hang guard
  // ---------------------------------------------------------------
  initial begin
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  // Cuts the run short well beyond the roughly two hundred cycles needed
  always @(posedge sys_clk_i) begin
    cycle_cnt++;
    if (cycle_cnt == 5000) begin
      error_cnt++;
      $display("ERROR at %0t ns: run did not finish in time", $time);
      complete_run();
    end
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask : tick

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] addr, input logic [15:0] data);
    tick(1);
    reg_addr_i = addr;
    reg_wdata_i = data;
    reg_wr_i = 1'b1;
    tick(1);
    reg_wr_i = 1'b0;
  endtask : wr

  // Read strobe, then rvalid and data stand for the following cycle only
  task automatic rd(input logic [7:0] addr, input logic [15:0] exp);
    tick(1);
    reg_addr_i = addr;
    reg_rd_i = 1'b1;
    tick(1);
    reg_rd_i = 1'b0;
    chk(reg_rvalid_o, 16'h0001, "read valid");
    chk(reg_rdata_o, exp, "read data");
  endtask : rd

  // Sequencer event, kind is {enter_off, enter_active, shutdown, startup}
  task automatic seq(input logic [3:0] kind, input logic [3:0] slot);
    tick(1);
    {seq_enter_off_i, seq_enter_active_i, seq_shutdown_stb_i, seq_startup_stb_i} = kind;
    seq_slot_i = slot;
    tick(1);
    {seq_enter_off_i, seq_enter_active_i, seq_shutdown_stb_i, seq_startup_stb_i} = 4'h0;
  endtask : seq

  function automatic logic [15:0] sw_word(input logic [1:0] fa, input logic [3:0] su,
                                          input logic [3:0] sd, input logic keep,
                                          input logic [1:0] prot);
    return {fa, su, sd, 1'b0, keep, 2'b00, prot};
  endfunction : sw_word

  task automatic sw_chk(input logic en, input logic bulk);
    chk(switch_en_o, en, "switch enable");
    chk(bulk_detect_en_o, bulk, "bulk detect");
  endtask : sw_chk

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic test_reset();
    rd(CSL_CONV6_HIB_CFG_ADDR, 16'h0006);
    rd(CSL_SWITCH_CTRL_ADDR, 16'h0003);
    tick(1);
    chk(reg_rvalid_o, 16'h0000, "read valid drop");
    chk(reg_rdata_o, 16'h0000, "read data drop");
    rd(8'hc6, 16'h0000);
    chk(conv_image_voltage_o, 16'h0006, "image after reset");
    sw_chk(1'b0, 1'b1);
    $display("test reset done");
  endtask : test_reset

  task automatic test_modes();
    wr(CSL_CONV6_HIB_CFG_ADDR, 16'hffff);
    rd(CSL_CONV6_HIB_CFG_ADDR, 16'h737f);
    for (int m = 0; m < 8; m++) begin
      wr(CSL_CONV6_HIB_CFG_ADDR, {1'b0, m[2:0], 5'h00, 7'h66});
      hibernate_reg_bit_i = 1'b1;
      tick(1);
      chk(conv_hib_active_o, 16'h0001, "hibernate on");
      chk({conv_disable_o, conv_linear_mode_o, conv_standby_o, conv_use_image_o},
          mode_exp[m], "behaviour outputs");
      chk(conv_image_voltage_o, 16'h0066, "image voltage");
      hibernate_reg_bit_i = 1'b0;
      tick(1);
      chk({conv_hib_active_o, conv_disable_o, conv_linear_mode_o, conv_standby_o,
           conv_use_image_o}, 16'h0000, "hibernate released");
    end
    $display("test modes done");
  endtask : test_modes

  task automatic test_sources();
    for (int s = 0; s < 4; s++) begin
      wr(CSL_CONV6_HIB_CFG_ADDR, {4'h1, 2'b00, s[1:0], 8'h06});
      for (int j = 0; j < 4; j++) begin
        {low_power_request_3_i, low_power_request_2_i, low_power_request_1_i,
         hibernate_reg_bit_i} = 4'h1 << j;
        tick(1);
        chk(conv_hib_active_o, (s == j), "source select");
        {low_power_request_3_i, low_power_request_2_i, low_power_request_1_i,
         hibernate_reg_bit_i} = 4'h0;
        gpio_hibernate_i = 1'b1;
        tick(1);
        chk(conv_hib_active_o, 16'h0001, "pin hibernate");
        gpio_hibernate_i = 1'b0;
        tick(1);
      end
    end
    $display("test sources done");
  endtask : test_sources

  task automatic test_slots();
    wr(CSL_SWITCH_CTRL_ADDR, sw_word(2'b00, 4'h3, 4'he, 1'b0, 2'b01));
    seq(4'h1, 4'h2);
    sw_chk(1'b0, 1'b1);
    seq(4'h1, 4'h3);
    sw_chk(1'b1, 1'b0);
    seq(4'h2, 4'h3);
    sw_chk(1'b1, 1'b0);
    seq(4'h2, 4'he);
    sw_chk(1'b0, 1'b1);
    wr(CSL_SWITCH_CTRL_ADDR, sw_word(2'b00, 4'hf, 4'h0, 1'b0, 2'b10));
    seq(4'h4, 4'h0);
    sw_chk(1'b1, 1'b0);
    seq(4'h8, 4'h0);
    sw_chk(1'b0, 1'b0);
    wr(CSL_SWITCH_CTRL_ADDR, sw_word(2'b00, 4'h0, 4'hf, 1'b0, 2'b11));
    seq(4'h4, 4'h0);
    sw_chk(1'b0, 1'b1);
    wr(CSL_SWITCH_CTRL_ADDR, sw_word(2'b00, 4'h1, 4'hf, 1'b0, 2'b11));
    seq(4'h1, 4'h1);
    sw_chk(1'b1, 1'b0);
    seq(4'h8, 4'h0);
    sw_chk(1'b0, 1'b1);
    $display("test slots done");
  endtask : test_slots

  task automatic test_faults();
    for (int a = 0; a < 4; a++) begin
      wr(CSL_SWITCH_CTRL_ADDR, sw_word(a[1:0], 4'h1, 4'he, 1'b0, 2'b11));
      seq(4'h1, 4'h1);
      overcurrent_i = 1'b1;
      tick(1);
      chk(fault_irq_o, (a != 0), "fault interrupt");
      chk(system_shutdown_o, a[1], "system shutdown");
      chk(switch_en_o, (a != 1), "switch after fault");
      tick(1);
      chk({fault_irq_o, system_shutdown_o}, 16'h0000, "fault pulse width");
      overcurrent_i = 1'b0;
      seq(4'h2, 4'he);
    end
    overcurrent_i = 1'b1;
    tick(1);
    chk({fault_irq_o, system_shutdown_o}, 16'h0000, "fault while off");
    overcurrent_i = 1'b0;
    $display("test faults done");
  endtask : test_faults

  task automatic test_hib_switch();
    wr(CSL_CONV6_HIB_CFG_ADDR, 16'h0006);
    wr(CSL_SWITCH_CTRL_ADDR, sw_word(2'b00, 4'h1, 4'he, 1'b0, 2'b10));
    seq(4'h1, 4'h1);
    hibernate_reg_bit_i = 1'b1;
    tick(1);
    sw_chk(1'b0, 1'b1);
    hibernate_reg_bit_i = 1'b0;
    tick(1);
    sw_chk(1'b1, 1'b0);
    wr(CSL_SWITCH_CTRL_ADDR, sw_word(2'b00, 4'h1, 4'he, 1'b1, 2'b01));
    hibernate_reg_bit_i = 1'b1;
    tick(1);
    sw_chk(1'b1, 1'b0);
    seq(4'h2, 4'he);
    sw_chk(1'b0, 1'b0);
    hibernate_reg_bit_i = 1'b0;
    tick(1);
    sw_chk(1'b0, 1'b1);
    $display("test hibernate switch done");
  endtask : test_hib_switch

  task automatic test_psm();
    wr(CSL_CONV6_HIB_CFG_ADDR, 16'h5266);
    wr(CSL_SWITCH_CTRL_ADDR, 16'hffd3);
    tick(1);
    psm_reset_i = 1'b1;
    reg_addr_i = CSL_SWITCH_CTRL_ADDR;
    reg_wdata_i = 16'h4000;
    reg_wr_i = 1'b1;
    tick(1);
    psm_reset_i = 1'b0;
    reg_wr_i = 1'b0;
    rd(CSL_CONV6_HIB_CFG_ADDR, 16'h0006);
    rd(CSL_SWITCH_CTRL_ADDR, 16'h0003);
    chk(conv_image_voltage_o, 16'h0006, "image after restore");
    $display("test state machine restore done");
  endtask : test_psm

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    tick(1);
    chk({switch_en_o, fault_irq_o, reg_rvalid_o}, 16'h0000, "outputs in reset");
    chk(conv_image_voltage_o, 16'h0006, "image in reset");
    tick(1);
    reset_i = 1'b0;
    tick(1);
    test_reset();
    test_modes();
    test_sources();
    test_slots();
    test_faults();
    test_hib_switch();
    test_psm();
    complete_run();
  end

endmodule : csl_ctrl_test

// File: csl_pkg.sv
// Constants, field layouts and carriers for the converter/switch low-power control slice
package csl_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] CSL_CONV6_HIB_CFG_ADDR = 8'hc5;
  localparam logic [7:0] CSL_SWITCH_CTRL_ADDR = 8'hc7;

  // ---------------------------------------------------------------
  // Field codes
  // ---------------------------------------------------------------
  localparam logic [2:0] CSL_HIB_KEEP = 3'h0;
  localparam logic [2:0] CSL_HIB_IMAGE = 3'h1;
  localparam logic [2:0] CSL_HIB_STANDBY = 3'h2;
  localparam logic [2:0] CSL_HIB_STANDBY_IMAGE = 3'h3;
  localparam logic [2:0] CSL_HIB_LINEAR = 3'h4;
  localparam logic [2:0] CSL_HIB_LINEAR_IMAGE = 3'h5;
  localparam logic [2:0] CSL_HIB_RESERVED = 3'h6;
  localparam logic [2:0] CSL_HIB_DISABLE = 3'h7;

  localparam logic [1:0] CSL_SRC_SW_BIT = 2'h0;
  localparam logic [1:0] CSL_SRC_LPR1 = 2'h1;
  localparam logic [1:0] CSL_SRC_LPR2 = 2'h2;
  localparam logic [1:0] CSL_SRC_LPR3 = 2'h3;

  localparam logic [1:0] CSL_FAULT_IGNORE = 2'h0;
  localparam logic [1:0] CSL_FAULT_DISABLE = 2'h1;
  localparam int CSL_FAULT_SYS_BIT = 1; // Set in both system shutdown codes

  localparam logic [3:0] CSL_SLOT_NONE = 4'h0;
  localparam logic [3:0] CSL_SLOT_EDGE = 4'hf;

  // ---------------------------------------------------------------
  // Defaults restored by reset and by the power state machine
  // ---------------------------------------------------------------
  localparam logic [2:0] CSL_DEF_BEHAVIOUR = 3'h0;
  localparam logic [1:0] CSL_DEF_SOURCE = 2'h0;
  localparam logic [6:0] CSL_DEF_IMAGE_VOLT = 7'h06;
  localparam logic [1:0] CSL_DEF_FAULT_ACTION = 2'h0;
  localparam logic [3:0] CSL_DEF_STARTUP_SLOT = 4'h0;
  localparam logic [3:0] CSL_DEF_SHUTDOWN_SLOT = 4'h0;
  localparam logic CSL_DEF_HIB_KEEP = 1'b0;
  localparam logic CSL_DEF_BULK_HIB = 1'b1;
  localparam logic CSL_DEF_BULK_ACT = 1'b1;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] conv_hibernate_behaviour;
    logic [1:0] conv_hibernate_source_sel;
    logic [6:0] conv_image_voltage;
  } csl_conv_cfg_type;

  typedef struct packed {
    logic [1:0] switch_fault_action;
    logic [3:0] switch_startup_slot;
    logic [3:0] switch_shutdown_slot;
    logic switch_hibernate_keep;
    logic switch_bulk_detect_hibernate;
    logic switch_bulk_detect_active;
  } csl_sw_cfg_type;

  typedef struct packed {
    logic disable_out;
    logic linear_mode;
    logic standby;
    logic use_image;
  } csl_conv_ctrl_type;

  // Register word layouts, reserved bits read as zero
  typedef struct packed {
    logic rsv_15;
    logic [2:0] conv_hibernate_behaviour;
    logic [1:0] rsv_11_10;
    logic [1:0] conv_hibernate_source_sel;
    logic rsv_7;
    logic [6:0] conv_image_voltage;
  } csl_conv_word_type;

  typedef struct packed {
    logic [1:0] switch_fault_action;
    logic [3:0] switch_startup_slot;
    logic [3:0] switch_shutdown_slot;
    logic rsv_5;
    logic switch_hibernate_keep;
    logic [1:0] rsv_3_2;
    logic switch_bulk_detect_hibernate;
    logic switch_bulk_detect_active;
  } csl_sw_word_type;

  localparam csl_conv_cfg_type CSL_CONV_DEFAULT =
    '{CSL_DEF_BEHAVIOUR, CSL_DEF_SOURCE, CSL_DEF_IMAGE_VOLT};
  localparam csl_sw_cfg_type CSL_SW_DEFAULT =
    '{CSL_DEF_FAULT_ACTION, CSL_DEF_STARTUP_SLOT, CSL_DEF_SHUTDOWN_SLOT,
      CSL_DEF_HIB_KEEP, CSL_DEF_BULK_HIB, CSL_DEF_BULK_ACT};

endpackage : csl_pkg
